/* logic/low_freq_clock_gate_prescale.sv */
`timescale 1ns/1ns
`default_nettype none
`include "lf_clock_defs.svh"

// Notes on behaviour
// - Busy flags bits 0,2,4,6 read 1 while enable/prescaler values synchronise.
// - Freeze bit holds all slow-domain transfers not yet requested; clearing applies pending values together.
// - Branch-A gate bit 3 enables the display driver clock.
// - Branch-A gate bit 2 enables the low-energy timer clock.
// - Branch-A gate bit 1 enables the real-time counter clock.
// - Branch-A gate bit 0 enables the sensor interface clock.
// - Branch-B gate bit 1 enables serial port 1 clock.
// - Branch-B gate bit 0 enables serial port 0 clock.
// - RTC divider bits 7:4 divide branch A by two to the field.
// - Timer divider divides branch A by two to the field, up to 32768.
// - Sensor divider bits 1:0 divide branch A by 1,2,4,8.
// - Serial 1 divider bits 5:4 divide branch B by 1,2,4,8.
// - Serial 0 divider bits 1:0 divide branch B by 1,2,4,8.
// - Enable and prescaler registers move into the slow domain, not instantly.
// - Pulse-counter register holds gate and select per counter, bits 5:0.
// - Counter select 0 picks branch A, 1 picks the external pin.
// - Counter gate 0 stops the counter clock, 1 enables it.
module low_freq_clock_gate_prescale #(
    parameter int DIV_W = 15
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lowFreqAClockTick,
    input wire logic lowFreqBClockTick,
    input wire logic [2:0] counterExtInput,
    output logic displayClockEn,
    output logic timerClockEn,
    output logic rtcClockEn,
    output logic sensorClockEn,
    output logic serial0ClockEn,
    output logic serial1ClockEn,
    output logic [2:0] counterClockEn,
    output logic [2:0] counterClockOut
);

    // Index of each asynchronous register in the transfer arrays
    localparam int N_ASYNC = 4;
    localparam int IX_AG = 0;
    localparam int IX_AD = 1;
    localparam int IX_BG = 2;
    localparam int IX_BD = 3;

    logic [31:0] shadowReg [N_ASYNC];
    logic [31:0] slowReg [N_ASYNC];
    // One element per slot, so each generate process owns its own variable
    logic pendReg [N_ASYNC];
    logic busyReg [N_ASYNC];
    lf_clock_pkg::sync_state_t syncStateReg [N_ASYNC];
    logic freezeReg;
    logic [5:0] pcntReg;
    logic [DIV_W-1:0] divAReg;
    logic [2:0] divBReg;
    logic accessPhase;
    logic wrEn;
    logic rdEn;
    logic addrOk;

    // Bus timing
    // Setup cycle, then access cycle, then the answer cycle.
    // Ready is registered high at the first access edge.
    // A write lands on the edge that sees ready high.
    // Read data is registered at the first access edge.
    // So read data stands from the edge that raises ready until the next read.
    // Error pulses together with ready.
    // An unmapped write changes nothing.
    // An unmapped read returns zero.

    // Register groups
    // Freeze and pulse-counter control act at once.
    // The four slow-domain registers keep a bus-side shadow.
    // Reads of those return the shadow, not the live value.
    // Software therefore sees its write before it takes effect.
    // The busy flag tells when the live value has caught up.

    // Slow-domain transfer
    // A write sets pending and busy on the same edge.
    // Pending waits while freeze is set.
    // With freeze clear the slot raises a request.
    // The request is served on the next tick of its branch.
    // That tick copies shadow into the live register.
    // One cycle later busy drops.
    // A write arriving in that cycle keeps busy set.
    // Set wins over clear there, but a write landing on the capture edge itself loses its pending flag and never goes live.

    // Hazards
    // A rewrite while a request stands replaces the shadow.
    // The latest value written before the capture tick is the one captured.
    // Software should still wait for busy to clear.
    // Otherwise it cannot tell which value went live.
    // Reserved bits are masked off on write.
    // So reserved bits always read back as zero.

    // Freeze
    // Freeze only holds back new requests.
    // A request already raised is not withdrawn.
    // Several writes made under freeze go live together.
    // They go live on the first branch tick after the request, which is raised one edge after release.
    // Branch A and branch B slots still use their own ticks.
    // So the two branches may change one tick apart.

    // Slow clocks
    // Both slow clocks arrive as one-cycle tick enables.
    // Nothing here runs on a second clock.
    // This avoids real domain crossings inside the block.
    // The trade is that ticks must be clean single pulses.
    // A tick held high for two cycles counts twice.

    // Dividers
    // Each branch has one free-running counter.
    // A prescaled output fires when the low field bits are all ones.
    // That gives one pulse per two-to-the-field ticks.
    // All prescaled outputs of one branch share the counter; display and the pulse counters do not use it.
    // So divided outputs stay phase aligned to each other.
    // Changing a field takes effect at the next matching count.
    // The first divided pulse after a change may come early.
    // Branch B needs only divide by eight, so its counter is small.

    // Gates
    // A gate bit masks the tick into its output.
    // A cleared gate stops the output at the next tick.
    // No partial pulse can appear, since outputs are whole cycles.

    // Pulse counters
    // Each counter has a gate bit and a select bit.
    // Select low passes the branch-A tick.
    // Select high passes the external pin level.
    // The pin path has one register of delay.
    // Pin levels are taken as already synchronous.
    // The enable output mirrors the gate bit.

    // Outputs
    // Every output comes from a flip-flop.
    // All outputs read zero during and after reset.
    // The first bus setup may follow reset at once.

    // Map a register offset onto an asynchronous slot index, -1 if none
    function automatic int async_index(input logic [11:0] addr);
        case (addr)
            `OFF_A_GATES: async_index = IX_AG;
            `OFF_A_DIVIDERS: async_index = IX_AD;
            `OFF_B_GATES: async_index = IX_BG;
            `OFF_B_DIVIDERS: async_index = IX_BD;
            default: async_index = -1;
        endcase
    endfunction

    // Writable mask per asynchronous slot
    function automatic logic [31:0] async_mask(input int idx);
        case (idx)
            IX_AG: async_mask = `MASK_A_GATES;
            IX_AD: async_mask = `MASK_A_DIV;
            IX_BG: async_mask = `MASK_B_GATES;
            default: async_mask = `MASK_B_DIV;
        endcase
    endfunction

    // Tick when a free-running divider crosses a power-of-two boundary
    function automatic logic div_tick(input logic [DIV_W-1:0] cnt, input logic [3:0] shift);
        logic [DIV_W-1:0] m;
        m = DIV_W'((32'h1 << shift) - 32'h1);
        div_tick = ((cnt & m) == m);
    endfunction

    // APB decode; one-wait slave, answer in the cycle after the first access edge
    assign accessPhase = psel && penable;
    assign addrOk = (paddr == `OFF_SYNC_BUSY) || (paddr == `OFF_FREEZE) || (paddr == `OFF_PCNT_CLOCKING)
        || (async_index(paddr) >= 0);
    assign wrEn = accessPhase && pwrite && addrOk && pready;
    assign rdEn = accessPhase && !pwrite && !pready;

    // Ready pulses for one cycle per access; unmapped address gets pslverr
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= accessPhase && !pready;
            pslverr <= accessPhase && !pready && !addrOk;
        end
    end

    // Read data mux; reserved bits read zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prdata <= `RESET_VALUE;
        else if (rdEn)
        begin
            prdata <= `RESET_VALUE;
            case (paddr)
                `OFF_SYNC_BUSY:
                begin
                    prdata[`BUSY_A_GATES] <= busyReg[IX_AG];
                    prdata[`BUSY_A_DIV] <= busyReg[IX_AD];
                    prdata[`BUSY_B_GATES] <= busyReg[IX_BG];
                    prdata[`BUSY_B_DIV] <= busyReg[IX_BD];
                end
                `OFF_FREEZE: prdata[`FREEZE_BIT] <= freezeReg;
                `OFF_PCNT_CLOCKING: prdata[5:0] <= pcntReg;
                `OFF_A_GATES: prdata <= shadowReg[IX_AG];
                `OFF_A_DIVIDERS: prdata <= shadowReg[IX_AD];
                `OFF_B_GATES: prdata <= shadowReg[IX_BG];
                `OFF_B_DIVIDERS: prdata <= shadowReg[IX_BD];
                default: prdata <= `RESET_VALUE;
            endcase
        end
    end

    // Freeze and pulse-counter control take effect at once
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            freezeReg <= 1'b0;
            pcntReg <= 6'h00;
        end
        else if (wrEn && paddr == `OFF_FREEZE)
            freezeReg <= pwdata[`FREEZE_BIT];
        else if (wrEn && paddr == `OFF_PCNT_CLOCKING)
            pcntReg <= pwdata[5:0];
    end

    // Bus-side shadow copies; a write marks the value pending and busy at once
    // Handshake per slot: pending waits out freeze, then request, then slow capture
    for (genvar i = 0; i < N_ASYNC; i++)
    begin : g_async
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                shadowReg[i] <= `RESET_VALUE;
                pendReg[i] <= 1'b0;
                busyReg[i] <= 1'b0;
                slowReg[i] <= `RESET_VALUE;
                syncStateReg[i] <= lf_clock_pkg::SYNC_IDLE;
            end
            else
            begin
                if (wrEn && async_index(paddr) == i)
                begin
                    shadowReg[i] <= pwdata & async_mask(i);
                    pendReg[i] <= 1'b1;
                    busyReg[i] <= 1'b1;
                end
                case (syncStateReg[i])
                    lf_clock_pkg::SYNC_IDLE:
                        if (pendReg[i] && !freezeReg && !(wrEn && async_index(paddr) == i))
                            syncStateReg[i] <= lf_clock_pkg::SYNC_REQ;
                    lf_clock_pkg::SYNC_REQ:
                        // Slow domain captures on its next branch tick
                        if ((i < IX_BG) ? lowFreqAClockTick : lowFreqBClockTick)
                        begin
                            slowReg[i] <= shadowReg[i];
                            pendReg[i] <= 1'b0;
                            syncStateReg[i] <= lf_clock_pkg::SYNC_ACK;
                        end
                    lf_clock_pkg::SYNC_ACK:
                    begin
                        // A write landing now keeps busy set: set wins
                        if (!(wrEn && async_index(paddr) == i))
                            busyReg[i] <= 1'b0;
                        syncStateReg[i] <= lf_clock_pkg::SYNC_IDLE;
                    end
                    default: syncStateReg[i] <= lf_clock_pkg::SYNC_IDLE;
                endcase
            end
        end
    end

    // Branch-A divider chain counts on branch-A ticks only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            divAReg <= '0;
        else if (lowFreqAClockTick)
            divAReg <= divAReg + DIV_W'(1);
    end

    // Branch-B divider chain; only divide-by-8 needed there
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            divBReg <= 3'h0;
        else if (lowFreqBClockTick)
            divBReg <= divBReg + 3'h1;
    end

    // Branch-A enables: gate and prescaler together (display is gate only), one pulse per divided period
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            displayClockEn <= 1'b0;
            timerClockEn <= 1'b0;
            rtcClockEn <= 1'b0;
            sensorClockEn <= 1'b0;
        end
        else
        begin
            displayClockEn <= lowFreqAClockTick && slowReg[IX_AG][`GATE_A_DISPLAY];
            timerClockEn <= lowFreqAClockTick && slowReg[IX_AG][`GATE_A_TIMER]
                && div_tick(divAReg, slowReg[IX_AD][`DIV_A_TIMER_HI:`DIV_A_TIMER_LO]);
            rtcClockEn <= lowFreqAClockTick && slowReg[IX_AG][`GATE_A_RTC]
                && div_tick(divAReg, slowReg[IX_AD][`DIV_A_RTC_HI:`DIV_A_RTC_LO]);
            sensorClockEn <= lowFreqAClockTick && slowReg[IX_AG][`GATE_A_SENSOR]
                && div_tick(divAReg, {2'b00, slowReg[IX_AD][`DIV_A_SENSOR_HI:`DIV_A_SENSOR_LO]});
        end
    end

    // Branch-B enables for the two serial ports
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            serial0ClockEn <= 1'b0;
            serial1ClockEn <= 1'b0;
        end
        else
        begin
            serial1ClockEn <= lowFreqBClockTick && slowReg[IX_BG][`GATE_B_SERIAL1]
                && div_tick(DIV_W'(divBReg), {2'b00, slowReg[IX_BD][`DIV_B_SERIAL1_HI:`DIV_B_SERIAL1_LO]});
            serial0ClockEn <= lowFreqBClockTick && slowReg[IX_BG][`GATE_B_SERIAL0]
                && div_tick(DIV_W'(divBReg), {2'b00, slowReg[IX_BD][`DIV_B_SERIAL0_HI:`DIV_B_SERIAL0_LO]});
        end
    end

    // Pulse counters: select picks branch-A tick or pin level, gate forces low
    // Pin path is registered once, so the counter sees a one-cycle delay
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            counterClockEn <= 3'h0;
            counterClockOut <= 3'h0;
        end
        else
        begin
            for (int k = 0; k < 3; k++)
            begin
                counterClockEn[k] <= pcntReg[2*k];
                counterClockOut[k] <= pcntReg[2*k]
                    && (pcntReg[2*k+1] ? counterExtInput[k] : lowFreqAClockTick);
            end
        end
    end

endmodule // low_freq_clock_gate_prescale
`default_nettype wire

/* inc/lf_clock_defs.svh */
`ifndef LF_CLOCK_DEFS_SVH
`define LF_CLOCK_DEFS_SVH

// Register byte offsets
`define OFF_SYNC_BUSY 12'h050
`define OFF_FREEZE 12'h054
`define OFF_A_GATES 12'h058
`define OFF_B_GATES 12'h060
`define OFF_A_DIVIDERS 12'h068
`define OFF_B_DIVIDERS 12'h070
`define OFF_PCNT_CLOCKING 12'h078

// Busy flag positions
`define BUSY_A_GATES 0
`define BUSY_A_DIV 2
`define BUSY_B_GATES 4
`define BUSY_B_DIV 6

// Field positions
`define GATE_A_DISPLAY 3
`define GATE_A_TIMER 2
`define GATE_A_RTC 1
`define GATE_A_SENSOR 0
`define GATE_B_SERIAL1 1
`define GATE_B_SERIAL0 0
`define DIV_A_TIMER_HI 11
`define DIV_A_TIMER_LO 8
`define DIV_A_RTC_HI 7
`define DIV_A_RTC_LO 4
`define DIV_A_SENSOR_HI 1
`define DIV_A_SENSOR_LO 0
`define DIV_B_SERIAL1_HI 5
`define DIV_B_SERIAL1_LO 4
`define DIV_B_SERIAL0_HI 1
`define DIV_B_SERIAL0_LO 0
`define FREEZE_BIT 0

// Writable masks and reset value
`define MASK_A_GATES 32'h0000000F
`define MASK_B_GATES 32'h00000003
`define MASK_A_DIV 32'h00000FF3
`define MASK_B_DIV 32'h00000033
`define MASK_PCNT 32'h0000003F
`define MASK_FREEZE 32'h00000001
`define RESET_VALUE 32'h00000000

`endif

/* inc/lf_clock_pkg.sv */
package lf_clock_pkg;
    // Per-register synchroniser handshake state
    typedef enum logic [2:0]
    {
        SYNC_IDLE = 3'b001,
        SYNC_REQ = 3'b010,
        SYNC_ACK = 3'b100
    } sync_state_t;
endpackage

/* tb/lf_periph_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Slow oscillators and counter pins as the peripherals see them
module lf_periph_model #(
    parameter int PER_A = 3,
    parameter int PER_B = 4
)
(
    input wire logic clk,
    input wire logic rst_n,
    output logic tickA,
    output logic tickB,
    output logic [2:0] pins
);
    int cntA;
    int cntB;
    // Ticks one cycle wide; pins move every cycle so a stale sample shows
    always_ff @(posedge clk)
    begin
        cntA <= (!rst_n || cntA >= PER_A - 1) ? 0 : cntA + 1;
        cntB <= (!rst_n || cntB >= PER_B - 1) ? 0 : cntB + 1;
        tickA <= rst_n && cntA == PER_A - 1;
        tickB <= rst_n && cntB == PER_B - 1;
        pins <= rst_n ? {pins[1:0], ~pins[2]} : 3'h1;
    end
endmodule // lf_periph_model
`default_nettype wire

/* tb/lf_clock_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "lf_clock_defs.svh"
// Port watcher for bus timing and clock outputs
module lf_clock_props #(
    parameter int DIV_W = 15
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic lowFreqAClockTick,
    input wire logic lowFreqBClockTick,
    input wire logic [2:0] counterExtInput,
    input wire logic displayClockEn,
    input wire logic timerClockEn,
    input wire logic rtcClockEn,
    input wire logic sensorClockEn,
    input wire logic serial0ClockEn,
    input wire logic serial1ClockEn,
    input wire logic [2:0] counterClockEn,
    input wire logic [2:0] counterClockOut
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Access phase before the answer, then a one-cycle answer
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_one_wait;
        s_access |=> s_answer;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("late or long ready");
    property p_err_ready;
        pslverr |-> pready && psel;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("stray error");
    property p_busy_rsv;
        pready && !pwrite && paddr == `OFF_SYNC_BUSY |-> (prdata & ~32'h55) == 32'h0;
    endproperty
    a_busy_rsv: assert property (p_busy_rsv) else $error("busy bits misplaced");
    property p_pcnt_rsv;
        pready && !pwrite && paddr == `OFF_PCNT_CLOCKING |-> prdata[31:6] == 26'h0;
    endproperty
    a_pcnt_rsv: assert property (p_pcnt_rsv) else $error("counter reg too wide");
    property p_branch_a;
        displayClockEn || timerClockEn || rtcClockEn || sensorClockEn |-> $past(lowFreqAClockTick);
    endproperty
    a_branch_a: assert property (p_branch_a) else $error("A pulse without tick");
    property p_branch_b;
        serial0ClockEn || serial1ClockEn |-> $past(lowFreqBClockTick);
    endproperty
    a_branch_b: assert property (p_branch_b) else $error("B pulse without tick");
    property p_cnt_gate;
        (counterClockOut & ~counterClockEn) == 3'h0;
    endproperty
    a_cnt_gate: assert property (p_cnt_gate) else $error("ungated counter clock");
    property p_cnt_src;
        (counterClockOut & ~($past(counterExtInput) | {3{$past(lowFreqAClockTick)}})) == 3'h0;
    endproperty
    a_cnt_src: assert property (p_cnt_src) else $error("counter clock sourceless");
endmodule // lf_clock_props
bind low_freq_clock_gate_prescale lf_clock_props #(.DIV_W(DIV_W)) props_u (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lowFreqAClockTick(lowFreqAClockTick),
    .lowFreqBClockTick(lowFreqBClockTick), .counterExtInput(counterExtInput), .displayClockEn(displayClockEn),
    .timerClockEn(timerClockEn), .rtcClockEn(rtcClockEn), .sensorClockEn(sensorClockEn),
    .serial0ClockEn(serial0ClockEn), .serial1ClockEn(serial1ClockEn), .counterClockEn(counterClockEn),
    .counterClockOut(counterClockOut));
`default_nettype wire

/* tb/low_freq_clock_gate_prescale_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "lf_clock_defs.svh"
module low_freq_clock_gate_prescale_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, tickA, tickB, dispEn, timEn, rtcEn, senEn, s0En, s1En;
    logic [2:0] pins, cntEn, cntOut, pinPrev;
    logic [10:0] sig;
    logic [31:0] v[5];
    logic [11:0] wo[5] = '{`OFF_A_GATES, `OFF_B_GATES, `OFF_A_DIVIDERS, `OFF_B_DIVIDERS, `OFF_PCNT_CLOCKING};
    int bad_count = 0;
    int total_checks = 0;
    int seed = 32'h3057;
    int pc[11];
    int pp[3];
    int d[11];
    int dp[3];
    assign sig = {tickB, tickA, cntOut, s1En, s0En, senEn, rtcEn, timEn, dispEn};
    initial forever #20 clk = ~clk;
    low_freq_clock_gate_prescale dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lowFreqAClockTick(tickA), .lowFreqBClockTick(tickB), .counterExtInput(pins), .displayClockEn(dispEn),
        .timerClockEn(timEn), .rtcClockEn(rtcEn), .sensorClockEn(senEn), .serial0ClockEn(s0En),
        .serial1ClockEn(s1En), .counterClockEn(cntEn), .counterClockOut(cntOut));
    lf_periph_model peer_u (.clk(clk), .rst_n(rst_n), .tickA(tickA), .tickB(tickB), .pins(pins));
    // Running totals, updated late so snapshots never race
    always @(posedge clk)
    begin
        pinPrev <= pins;
        for (int i = 0; i < 11; i++) pc[i] <= pc[i] + sig[i];
        for (int i = 0; i < 3; i++) pp[i] <= pp[i] + pinPrev[i];
    end
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    // One transfer; request held until ready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] x);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= x;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        for (n = 1; pready !== 1'b1 && n < 20; n++) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        bad_count += (pready !== 1'b1);
        if (pready !== 1'b1) results();
    endtask
    // Software must not rewrite while a value is in flight
    task automatic settle();
        q = 32'h1;
        for (int n = 0; q !== 32'h0 && n < 100; n++) apb(1'b0, `OFF_SYNC_BUSY, 32'h0);
        chk("busy clear", 32'h0, q);
    endtask
    // Pulses over exactly 32 ticks of one branch
    task automatic win(input int j);
        int s[11];
        int t[3];
        s = pc;
        for (int n = 0; n < 20 && pc[j] == s[j]; n++) @(posedge clk);
        @(posedge clk);
        s = pc;
        t = pp;
        for (int n = 0; n < 400 && pc[j] - s[j] < 32; n++) @(posedge clk);
        repeat (2) @(posedge clk);
        for (int n = 0; n < 11; n++) d[n] = pc[n] - s[n];
        for (int n = 0; n < 3; n++) dp[n] = pp[n] - t[n];
    endtask
    function automatic logic [31:0] rnd(input int m);
        return $unsigned($random(seed)) % m;
    endfunction
    function automatic int want(input int i);
        case (i)
            0: return v[0][3] ? 32 : 0;
            1: return v[0][2] ? 32 >> v[2][11:8] : 0;
            2: return v[0][1] ? 32 >> v[2][7:4] : 0;
            3: return v[0][0] ? 32 >> v[2][1:0] : 0;
            4: return v[1][0] ? 32 >> v[3][1:0] : 0;
            5: return v[1][1] ? 32 >> v[3][5:4] : 0;
            default: return !v[4][2 * i - 12] ? 0 : v[4][2 * i - 11] ? dp[i - 6] : 32;
        endcase
    endfunction
    initial
    begin
        #3000000;
        bad_count++;
        results();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, wo[i], 32'h0);
            chk("reset value", 32'h0, q);
        end
        apb(1'b1, 12'h0FC, 32'hFFFFFFFF);
        chk("unmapped error", 32'h1, {31'h0, e});
        apb(1'b1, `OFF_SYNC_BUSY, 32'h55);
        apb(1'b0, `OFF_SYNC_BUSY, 32'h0);
        chk("busy read only", 32'h0, q);
        // Held writes must not move until the freeze lifts
        apb(1'b1, `OFF_FREEZE, 32'h1);
        apb(1'b1, `OFF_A_GATES, 32'hF);
        apb(1'b1, `OFF_B_GATES, 32'h3);
        win(9);
        apb(1'b0, `OFF_SYNC_BUSY, 32'h0);
        chk("busy frozen", 32'h11, q);
        chk("display held", 32'h0, d[0]);
        apb(1'b1, `OFF_FREEZE, 32'h0);
        settle();
        for (int r = 0; r < 7; r++)
        begin
            v[0] = r ? $random(seed) & `MASK_A_GATES : 32'hF;
            v[1] = r ? $random(seed) & `MASK_B_GATES : 32'h3;
            v[2] = r ? rnd(6) << 8 | rnd(6) << 4 | rnd(4) : 32'h0;
            v[3] = r ? rnd(4) << 4 | rnd(4) : 32'h33;
            v[4] = r ? $random(seed) & `MASK_PCNT : 32'h3F;
            for (int i = 0; i < 5; i++) apb(1'b1, wo[i], v[i]);
            settle();
            for (int i = 0; i < 5; i++)
            begin
                apb(1'b0, wo[i], 32'h0);
                chk("readback", v[i], q);
            end
            chk("counter gates", {29'h0, v[4][4], v[4][2], v[4][0]}, {29'h0, cntEn});
            win(9);
            for (int i = 0; i < 9; i++) if (i < 4 || i > 5) chk("branch A pulses", want(i), d[i]);
            win(10);
            chk("serial0 pulses", want(4), d[4]);
            chk("serial1 pulses", want(5), d[5]);
        end
        results();
    end
endmodule // low_freq_clock_gate_prescale_tb_top
`default_nettype wire
